//--- rtl/latched_status_interrupt_logic.sv
/*
 * latched status and interrupt logic of a dual framer: the parallel
 * control port, nine status-type registers per framer, the tester
 * info register, mask registers, the summary register and the
 * active-low interrupt output.
 * assumes strobes, address and data pins are asynchronous; status
 * sources come from logic on i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module latched_status_interrupt_logic (
    input  wire logic         i_mclk,
    input  wire logic         i_rstn,
    input  wire logic         i_rd_n,        // read strobe pin
    input  wire logic         i_wr_n,        // write strobe pin
    input  wire logic [7:0]   i_addr,        // address pins
    input  wire logic [7:0]   i_data,        // data bus, input side
    input  wire logic [143:0] i_status_src,  // framer sources, 8 per reg
    input  wire logic [7:0]   i_bert_src,    // tester sources
    output logic      [7:0]   o_data,        // data bus, output side
    output logic              o_data_oe_n,   // low while driving data
    output logic              o_int_n        // shared interrupt
);
    // group counts in short
    localparam int NG = status_irq_pkg::NUM_GROUPS;
    localparam int NS = status_irq_pkg::NUM_STAT;

    // port access phases, gray along idle-read and idle-write
    typedef enum logic [1:0] {
        PORT_IDLE  = 2'b00,
        PORT_READ  = 2'b01,
        PORT_WRITE = 2'b10
    } port_state_t;

    port_state_t port_state;          // current phase
    port_state_t next_port_state;

    logic [17:0] pin_level;           // filtered pins
    logic        rd_n_f;              // filtered read strobe
    logic        wr_n_f;              // filtered write strobe
    logic [7:0]  addr_f;              // filtered address
    logic [7:0]  data_f;              // filtered data

    logic [7:0]  acc_addr;            // address of current access
    logic [7:0]  next_acc_addr;
    logic [7:0]  next_data;
    logic        next_oe_n;
    logic        rd_done;             // one cycle, read ended
    logic        wr_done;             // one cycle, write ended

    logic [7:0]  irq_mask [status_irq_pkg::NUM_FRAMERS][3];
    logic [7:0]  next_irq_mask [status_irq_pkg::NUM_FRAMERS][3];
    logic [7:0]  bert_ctrl;           // bert_control_one
    logic [7:0]  next_bert_ctrl;

    logic [7:0]  copy [NG];           // readable copies
    logic [NG-1:0] grp_irq;           // per register requests
    logic [NG-1:0] hit;               // access selects the group
    logic [7:0]  grp_irq_mask [NG];   // mask feeding each group

    logic [7:0]  summary;             // interrupt_source_summary
    logic [7:0]  next_summary;
    logic        next_int_n;

    // fields of the filtered pin word
    assign rd_n_f = pin_level[17];
    assign wr_n_f = pin_level[16];
    assign addr_f = pin_level[15:8];
    assign data_f = pin_level[7:0];

    // every pin goes through the three-flop filter; costs 3-4 cycles
    // of latency but keeps strobes clean of metastability
    pin_sync #(
        .WIDTH   (18),
        .RST_VAL ({status_irq_pkg::RST_STROBE, 16'h0000})
    ) u_pins (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_pin   ({i_rd_n, i_wr_n, i_addr, i_data}),
        .o_level (pin_level)
    );

    // address decode of the status-type registers
    always_comb begin
        hit = '0;
        for (int f = 0; f < status_irq_pkg::NUM_FRAMERS; f++) begin
            for (int s = 0; s < NS; s++) begin
                if (acc_addr == ((f == 0) ? status_irq_pkg::BASE_FRAMER_A
                                          : status_irq_pkg::BASE_FRAMER_B)
                                 + 8'(s)) begin
                    hit[f*NS+s] = 1'b1;
                end
            end
        end
        // tester info register
        hit[status_irq_pkg::BERT_GROUP] = (acc_addr == status_irq_pkg::OFS_BIR);
    end

    // irq mask routed to each status register
    always_comb begin
        for (int g = 0; g < NG; g++) begin
            grp_irq_mask[g] = 8'h00;
        end
        // groups left at zero never interrupt
        for (int f = 0; f < status_irq_pkg::NUM_FRAMERS; f++) begin
            // only these registers reach the output
            grp_irq_mask[f*NS+status_irq_pkg::IDX_SR1]     = irq_mask[f][0];
            grp_irq_mask[f*NS+status_irq_pkg::IDX_SR2]     = irq_mask[f][1];
            grp_irq_mask[f*NS+status_irq_pkg::IDX_DL_STAT] = irq_mask[f][2];
        end
        grp_irq_mask[status_irq_pkg::BERT_GROUP] = bert_ctrl;
    end

    // one status register instance per group
    for (genvar g = 0; g < NG; g++) begin : g_stat
        localparam int IDX = g % NS;
        localparam logic [7:0] ALM =
            (g == status_irq_pkg::BERT_GROUP)   ? 8'h00 :
            (IDX == status_irq_pkg::IDX_SR1)    ? status_irq_pkg::ALARM_SR1 :
            (IDX == status_irq_pkg::IDX_RX_INFO_THREE)   ? status_irq_pkg::ALARM_RX_INFO_THREE : 8'h00;
        // live bits in the data-link registers
        localparam logic [7:0] LIV =
            (g != status_irq_pkg::BERT_GROUP && IDX >= status_irq_pkg::IDX_DL_STAT)
            ? status_irq_pkg::LIVE_DL : 8'h00;
        // tester group has its own source byte
        logic [7:0] src;
        if (g == status_irq_pkg::BERT_GROUP) begin : g_bert
            assign src = i_bert_src;
        end else begin : g_frm
            assign src = i_status_src[g*8 +: 8];
        end

        status_group #(
            .ALARM_BITS (ALM),
            .LIVE_BITS  (LIV)
        ) u_grp (
            .i_mclk     (i_mclk),
            .i_rstn     (i_rstn),
            .i_src      (src),
            .i_wr       (wr_done && hit[g]),
            .i_mask     (data_f),
            .i_rd_done  (rd_done && hit[g]),
            .i_irq_mask (grp_irq_mask[g]),
            .o_copy     (copy[g]),
            .o_irq      (grp_irq[g])
        );
    end

    // port phase and strobe ends
    always_comb begin
        next_port_state = port_state;
        next_acc_addr   = acc_addr;
        rd_done         = 1'b0;
        wr_done         = 1'b0;
        case (port_state)
            PORT_IDLE: begin
                // read has priority if both strobes fall together
                if (!rd_n_f) begin
                    next_port_state = PORT_READ;
                    next_acc_addr   = addr_f;
                end else if (!wr_n_f) begin
                    next_port_state = PORT_WRITE;
                    next_acc_addr   = addr_f;
                end
            end
            PORT_READ: begin
                if (rd_n_f) begin
                    // read end clears the read bits
                    rd_done         = 1'b1;
                    next_port_state = PORT_IDLE;
                end
            end
            PORT_WRITE: begin
                if (wr_n_f) begin
                    // data taken at the trailing edge of the strobe
                    wr_done         = 1'b1;
                    next_port_state = PORT_IDLE;
                end
            end
            default: begin
                // unused code returns to idle
                next_port_state = PORT_IDLE;
            end
        endcase
    end

    // read data and bus drive
    always_comb begin
        next_data = o_data;
        next_oe_n = 1'b1;
        if (port_state == PORT_READ && !rd_n_f) begin
            next_oe_n = 1'b0;
            next_data = 8'h00;   // unmapped offsets read zero
            // status-type copies
            for (int g = 0; g < NG; g++) begin
                if (hit[g]) begin
                    next_data = copy[g];
                end
            end
            // mask registers read back
            for (int f = 0; f < status_irq_pkg::NUM_FRAMERS; f++) begin
                for (int m = 0; m < 3; m++) begin
                    if (acc_addr == ((f == 0) ? status_irq_pkg::BASE_FRAMER_A
                                              : status_irq_pkg::BASE_FRAMER_B)
                                     + 8'(status_irq_pkg::IDX_IRQ_MASK_ONE + m)) begin
                        next_data = irq_mask[f][m];
                    end
                end
            end
            // tester control and summary
            if (acc_addr == status_irq_pkg::OFS_BC1) begin
                next_data = bert_ctrl;
            end
            if (acc_addr == status_irq_pkg::OFS_SUMMARY) begin
                next_data = summary;
            end
        end
    end

    // mask register writes
    always_comb begin
        next_irq_mask  = irq_mask;
        next_bert_ctrl = bert_ctrl;
        if (wr_done) begin
            for (int f = 0; f < status_irq_pkg::NUM_FRAMERS; f++) begin
                for (int m = 0; m < 3; m++) begin
                    // mask registers written by the host
                    if (acc_addr == ((f == 0) ? status_irq_pkg::BASE_FRAMER_A
                                              : status_irq_pkg::BASE_FRAMER_B)
                                     + 8'(status_irq_pkg::IDX_IRQ_MASK_ONE + m)) begin
                        next_irq_mask[f][m] = data_f;
                    end
                end
            end
            // tester control byte
            if (acc_addr == status_irq_pkg::OFS_BC1) begin
                next_bert_ctrl = data_f;
            end
        end
    end

    // summary and interrupt output
    always_comb begin
        next_summary = 8'h00;
        for (int f = 0; f < status_irq_pkg::NUM_FRAMERS; f++) begin
            next_summary[status_irq_pkg::SUM_SR1_A + 3*f] =
                grp_irq[f*NS+status_irq_pkg::IDX_SR1];
            next_summary[status_irq_pkg::SUM_SR2_A + 3*f] =
                grp_irq[f*NS+status_irq_pkg::IDX_SR2];
            next_summary[status_irq_pkg::SUM_DL_A + 3*f] =
                grp_irq[f*NS+status_irq_pkg::IDX_DL_STAT];
        end
        // tester request
        next_summary[status_irq_pkg::SUM_BERT] = grp_irq[status_irq_pkg::BERT_GROUP];
        // output low while any flag pending
        next_int_n = ~(|next_summary);
    end

    // registers of the port and summary
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            port_state  <= PORT_IDLE;
            acc_addr    <= status_irq_pkg::RST_BYTE;
            o_data      <= status_irq_pkg::RST_BYTE;
            o_data_oe_n <= 1'b1;
            irq_mask    <= '{default: '{default: status_irq_pkg::RST_BYTE}};
            bert_ctrl   <= status_irq_pkg::RST_BYTE;
            summary     <= status_irq_pkg::RST_BYTE;
            o_int_n     <= 1'b1;
        end else begin
            // outputs leave straight from flops
            port_state  <= next_port_state;
            acc_addr    <= next_acc_addr;
            o_data      <= next_data;
            o_data_oe_n <= next_oe_n;
            irq_mask    <= next_irq_mask;
            bert_ctrl   <= next_bert_ctrl;
            summary     <= next_summary;
            o_int_n     <= next_int_n;
        end
    end
endmodule
`default_nettype wire

//--- inc/status_irq_pkg.sv
/*
 * constants for the latched status and interrupt logic: register
 * offsets on the parallel control port, register group layout, alarm
 * and live bit masks, summary bit positions and reset values.
 * assumes one 200 MHz clock and an 8-bit address and data port.
 */
`default_nettype none
package status_irq_pkg;
    // two framers, each with nine status-type registers
    localparam int NUM_FRAMERS = 2;
    localparam int NUM_STAT    = 9;
    localparam int NUM_GROUPS  = NUM_FRAMERS * NUM_STAT + 1;
    localparam int BERT_GROUP  = NUM_FRAMERS * NUM_STAT;

    // status register index inside a framer block
    localparam int IDX_SR1     = 0;
    localparam int IDX_SR2     = 1;
    localparam int IDX_RX_INFO_ONE    = 2;
    localparam int IDX_RX_INFO_TWO    = 3;
    localparam int IDX_RX_INFO_THREE    = 4;
    localparam int IDX_DL_STAT = 5;   // hdlc_status_reg
    localparam int IDX_IRQ_MASK_ONE    = 9;   // irq_mask_one
    localparam int IDX_IRQ_MASK_TWO    = 10;  // irq_mask_two
    localparam int IDX_HDLC_IRQ_MASK    = 11;  // hdlc_irq_mask

    // block base offsets and shared registers
    localparam logic [7:0] BASE_FRAMER_A = 8'h20;
    localparam logic [7:0] BASE_FRAMER_B = 8'hA0;
    localparam logic [7:0] OFS_BC1       = 8'h0D;  // bert_control_one
    localparam logic [7:0] OFS_SUMMARY   = 8'h0E;  // interrupt_source_summary
    localparam logic [7:0] OFS_BIR       = 8'h0F;  // bert_info_reg

    // summary bit positions
    localparam int SUM_SR1_A = 0;
    localparam int SUM_SR2_A = 1;
    localparam int SUM_DL_A  = 2;
    localparam int SUM_SR1_B = 3;
    localparam int SUM_BERT  = 6;

    // alarm bits: set while present, interrupt on each change
    // sr1: blue, yellow, carrier loss, loss of sync
    localparam logic [7:0] ALARM_SR1  = 8'h0F;
    localparam logic [7:0] ALARM_RX_INFO_THREE = 8'h08;  // line carrier loss
    // live bits of the data-link status registers
    localparam logic [7:0] LIVE_DL    = 8'hC0;

    // reset values (power-up contents are otherwise undefined)
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [1:0] RST_STROBE = 2'h3;
endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
/*
 * three-flop synchroniser for a group of pins. a change counts once
 * the second and third flops agree; until then the old level holds.
 * assumes pins are asynchronous to i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int              WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1;       // metastable stage, read only by s2
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    // per bit: accept only agreed values
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (s2[i] == s3[i]) ? s3[i] : o_level[i];
        end
    end

    // shift chain and filtered level
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1      <= RST_VAL;
            s2      <= RST_VAL;
            s3      <= RST_VAL;
            o_level <= RST_VAL;
        end else begin
            s1      <= i_pin;
            s2      <= s1;
            s3      <= s2;
            o_level <= next_level;
        end
    end
endmodule
`default_nettype wire

//--- rtl/status_group.sv
/*
 * one 8-bit status-type register: latched bits, alarm bits, live
 * bits, the readable copy refreshed by a mask write, and the masked
 * interrupt request of the register.
 * assumes sources come from logic on i_mclk (no synchroniser).
 */
`timescale 1ns/1ps
`default_nettype none
module status_group #(
    parameter logic [7:0] ALARM_BITS = 8'h00,
    parameter logic [7:0] LIVE_BITS  = 8'h00
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_src,       // event pulses or alarm levels
    input  wire logic       i_wr,        // mask byte write, one cycle
    input  wire logic [7:0] i_mask,      // the byte written
    input  wire logic       i_rd_done,   // read of this register ended
    input  wire logic [7:0] i_irq_mask,  // 1 lets the bit interrupt
    output logic      [7:0] o_copy,      // readable copy
    output logic            o_irq        // any unmasked request
);
    localparam logic [7:0] EVT_BITS = ~(ALARM_BITS | LIVE_BITS);

    logic [7:0] latch;        // sticky bits
    logic [7:0] alarm_irq;    // alarm changed, not yet read
    logic [7:0] src_d;        // previous alarm levels
    logic [7:0] rd_sel;       // bits armed by the last mask write
    logic [7:0] next_latch;
    logic [7:0] next_alarm_irq;
    logic [7:0] next_copy;
    logic [7:0] next_rd_sel;
    logic [7:0] clr;
    logic [7:0] live_val;
    logic       next_irq;

    always_comb begin
        clr      = i_rd_done ? rd_sel : 8'h00;
        live_val = (latch & ~LIVE_BITS) | (i_src & LIVE_BITS);
        // latch events; read clears, alarms re-set while present
        // set wins over a clear in the same cycle
        next_latch = (latch & ~clr & ~LIVE_BITS) | (i_src & ~LIVE_BITS);
        // alarm irq on both edges; released by the read
        next_alarm_irq = (alarm_irq & ~clr) | ((i_src ^ src_d) & ALARM_BITS);
        // refresh where mask is one; hold where zero
        next_copy   = i_wr ? ((live_val & i_mask) | (o_copy & ~i_mask)) : o_copy;
        next_rd_sel = i_wr ? i_mask : (i_rd_done ? 8'h00 : rd_sel);
        // per-bit mask; event irq held until read
        next_irq    = |(((latch & EVT_BITS) | alarm_irq) & i_irq_mask);
    end

    // state registers; reset gives a clean start although the host
    // must still write every register after power-up
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch     <= status_irq_pkg::RST_BYTE;
            alarm_irq <= status_irq_pkg::RST_BYTE;
            src_d     <= status_irq_pkg::RST_BYTE;
            rd_sel    <= status_irq_pkg::RST_BYTE;
            o_copy    <= status_irq_pkg::RST_BYTE;
            o_irq     <= 1'b0;
        end else begin
            latch     <= next_latch;
            alarm_irq <= next_alarm_irq;
            src_d     <= i_src;
            rd_sel    <= next_rd_sel;
            o_copy    <= next_copy;
            o_irq     <= next_irq;
        end
    end
endmodule
`default_nettype wire

//--- dv/status_irq_asserts.sv
/*
 * port checker for the latched status and interrupt logic.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module status_irq_asserts (
    input wire logic         i_mclk,
    input wire logic         i_rstn,
    input wire logic         i_rd_n,
    input wire logic         i_wr_n,
    input wire logic [7:0]   i_addr,
    input wire logic [7:0]   i_data,
    input wire logic [143:0] i_status_src,
    input wire logic [7:0]   i_bert_src,
    input wire logic [7:0]   o_data,
    input wire logic         o_data_oe_n,
    input wire logic         o_int_n
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    reset_quiet_a : assert property ($rose(i_rstn) |-> o_int_n && o_data_oe_n)
        else $error("outputs active right after reset");
    drive_on_read_a : assert property ($fell(o_data_oe_n) |-> !i_rd_n && !$past(i_rd_n, 2))
        else $error("data driven without a held read strobe");
    release_bus_a : assert property ($rose(i_rd_n) |-> ##[1:8] o_data_oe_n)
        else $error("data bus not released after read");
    no_clash_a : assert property (!o_data_oe_n |-> i_wr_n)
        else $error("data driven during a write");
    // the unassigned summary bit is read as zero by design choice
    top_bit_a : assert property (!o_data_oe_n && i_addr == status_irq_pkg::OFS_SUMMARY |-> !o_data[7])
        else $error("summary top bit not zero");
    summary_idle_a : assert property ($fell(o_data_oe_n) && i_addr == status_irq_pkg::OFS_SUMMARY
        && o_int_n && $past(o_int_n, 2) |-> o_data[6:0] == 7'h00)
        else $error("summary pending while interrupt idle");
    int_hold_a : assert property ($fell(o_int_n) |-> (!o_int_n) [*4])
        else $error("interrupt dropped too soon");
    // a release must follow the end of a read a few edges earlier
    int_release_a : assert property ($rose(o_int_n)
        |-> !$past(i_rd_n, 7) || !$past(i_rd_n, 8) || !$past(i_rd_n, 9))
        else $error("interrupt released without a read");
    data_hold_a : assert property (o_data_oe_n && $past(o_data_oe_n) |-> $stable(o_data))
        else $error("idle read data changed");
endmodule
`default_nettype wire

//--- dv/host_cpu_model.sv
/*
 * host processor on the parallel control port: byte writes, byte
 * reads and the mask, read, write-back poll.
 * assumes strobes are filtered by the device over a few clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,   // device read data
    input  wire logic       i_oe_n,    // device drives data when low
    output var logic        o_rd_n,    // read strobe, active low
    output var logic        o_wr_n,    // write strobe, active low
    output var logic [7:0]  o_addr,    // register offset
    output var logic [7:0]  o_data     // write data
);
    // idle bus at time zero
    initial begin
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = 8'h00;
        o_data = 8'h00;
    end

    // strobe held long enough for the device filter to see both edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_data <= d;
        o_wr_n <= 1'b0;
        repeat (6) @(posedge i_mclk);
        o_wr_n <= 1'b1;
        repeat (6) @(posedge i_mclk);
        o_data <= ~d;  // a released bus does not keep the old byte
    endtask

    // read waits for the drive under a bound; a timeout gives unknown
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        d = 8'hxx;
        @(posedge i_mclk);
        o_addr <= a;
        o_rd_n <= 1'b0;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (i_oe_n !== 1'b0 && n < 20);
        if (n < 20) begin
            d = i_rdata;
        end
        o_rd_n <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (i_oe_n !== 1'b1 && n < 20);
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        wr(a, m);
        rd(a, d);
        wr(a, d & m);
    endtask
endmodule
`default_nettype wire

//--- dv/latched_status_interrupt_logic_bench.sv
/*
 * self-checking bench: a table of interrupt sources, then masked,
 * live-bit, alarm and unmapped cases by hand.
 * assumes the host model owns the control port pins.
 */
`timescale 1ns/1ps
`default_nettype none
module latched_status_interrupt_logic_bench;
    typedef struct {int src; logic [7:0] mask_addr; logic [7:0] stat_addr; logic [7:0] bit_val; int sum;} row_t;
    logic         i_mclk = 1'b0;
    logic         i_rstn = 1'b0;
    logic         i_rd_n, i_wr_n;
    logic [7:0]   i_addr, i_data, o_data;
    logic [143:0] i_status_src = '0;
    logic [7:0]   i_bert_src = '0;
    logic         o_data_oe_n, o_int_n;
    logic [7:0]   d;
    int           bad_count = 0;
    int           n_tests = 0;
    // one event source per summary bit; src below zero is the tester
    row_t rows [7] = '{
        '{4, 8'h29, 8'h20, 8'h10, 0}, '{8, 8'h2A, 8'h21, 8'h01, 1},
        '{40, 8'h2B, 8'h25, 8'h01, 2}, '{76, 8'hA9, 8'hA0, 8'h10, 3},
        '{80, 8'hAA, 8'hA1, 8'h01, 4}, '{112, 8'hAB, 8'hA5, 8'h01, 5},
        '{-1, 8'h0D, 8'h0F, 8'h01, 6}};

    always #2.5 i_mclk = ~i_mclk;

    latched_status_interrupt_logic dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
        .i_addr(i_addr), .i_data(i_data), .i_status_src(i_status_src), .i_bert_src(i_bert_src),
        .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_int_n(o_int_n));
    host_cpu_model host_u (.i_mclk(i_mclk), .i_rdata(o_data), .i_oe_n(o_data_oe_n), .o_rd_n(i_rd_n),
        .o_wr_n(i_wr_n), .o_addr(i_addr), .o_data(i_data));

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask
    // one-cycle source pulse, launched off a rising edge
    task automatic pulse(input int s, input logic [7:0] b);
        @(posedge i_mclk);
        if (s < 0) i_bert_src <= b;
        else i_status_src[s] <= 1'b1;
        @(posedge i_mclk);
        i_status_src <= '0;
        i_bert_src <= '0;
    endtask
    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog well beyond the expected run of under two thousand cycles
    initial begin
        repeat (40000) @(posedge i_mclk);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge i_mclk);
        chk1("int_n in reset", 1'b1, o_int_n);
        chk1("oe_n in reset", 1'b1, o_data_oe_n);
        i_rstn <= 1'b1;
        foreach (rows[k]) host_u.wr(rows[k].mask_addr, 8'h00);
        host_u.rd(status_irq_pkg::OFS_SUMMARY, d);
        chk8("summary idle", 8'h00, d);
        // ordinary cases: each unmasked source raises, reports, clears
        foreach (rows[k]) begin
            host_u.wr(rows[k].mask_addr, rows[k].bit_val);
            pulse(rows[k].src, rows[k].bit_val);
            repeat (6) @(posedge i_mclk);
            chk1("int_n raised", 1'b0, o_int_n);
            host_u.rd(status_irq_pkg::OFS_SUMMARY, d);
            chk8("summary", 8'(1 << rows[k].sum), d);
            host_u.poll(rows[k].stat_addr, rows[k].bit_val, d);
            chk8("latched bit", rows[k].bit_val, d);
            chk1("int_n released", 1'b1, o_int_n);
            host_u.poll(rows[k].stat_addr, rows[k].bit_val, d);
            chk8("cleared bit", 8'h00, d);
            host_u.wr(rows[k].mask_addr, 8'h00);
        end
        // masked and non-interrupting sources latch but stay quiet
        pulse(2 * 8 + 2, 8'h04);
        pulse(83, 8'h00);
        repeat (6) @(posedge i_mclk);
        chk1("int_n masked", 1'b1, o_int_n);
        host_u.poll(8'h22, 8'h00, d);
        chk8("zero mask hold", 8'h00, d);
        host_u.poll(8'h22, 8'h04, d);
        chk8("rx info bit", 8'h04, d);
        host_u.poll(8'hA1, 8'h08, d);
        chk8("masked bit", 8'h08, d);
        // a live bit gone before the read shows nothing
        pulse(47, 8'h00);
        host_u.poll(8'h25, 8'h80, d);
        chk8("live bit", 8'h00, d);
        // alarm: both edges interrupt, a read releases while present
        host_u.wr(8'h29, 8'h01);
        @(posedge i_mclk);
        i_status_src[0] <= 1'b1;
        repeat (6) @(posedge i_mclk);
        chk1("alarm on int", 1'b0, o_int_n);
        host_u.poll(8'h20, 8'h01, d);
        chk1("alarm read release", 1'b1, o_int_n);
        host_u.poll(8'h20, 8'h01, d);
        chk8("alarm stays", 8'h01, d);
        i_status_src[0] <= 1'b0;
        repeat (6) @(posedge i_mclk);
        chk1("alarm off int", 1'b0, o_int_n);
        host_u.poll(8'h20, 8'h01, d);
        chk1("alarm off release", 1'b1, o_int_n);
        host_u.rd(8'h01, d);
        chk8("unmapped read", 8'h00, d);
        host_u.rd(8'h29, d);
        chk8("mask readback", 8'h01, d);
        // mid-run reset drops a pending request and the masks
        host_u.wr(8'h29, 8'h10);
        pulse(4, 8'h00);
        repeat (6) @(posedge i_mclk);
        chk1("int_n before reset", 1'b0, o_int_n);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk1("int_n reset", 1'b1, o_int_n);
        i_rstn <= 1'b1;
        pulse(4, 8'h00);
        repeat (6) @(posedge i_mclk);
        chk1("mask after reset", 1'b1, o_int_n);
        close_out();
    end
endmodule

bind latched_status_interrupt_logic status_irq_asserts chk_u (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr), .i_data(i_data), .i_status_src(i_status_src),
    .i_bert_src(i_bert_src), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_int_n(o_int_n));
`default_nettype wire
